// ==== logic/pwc_pkg.sv ====
/*
 * Shared constants and types of the pulse width capture timer.
 * Assumes a 16-bit register port with four address bits and a single clock.
 */
package pwc_pkg;

    // ==========================================================
    // Register map, word addresses on the register port.
    localparam logic [3:0] ADDR_MODE     = 4'h0;
    localparam logic [3:0] ADDR_CONTROL  = 4'h1;
    localparam logic [3:0] ADDR_STATUS   = 4'h2;
    localparam logic [3:0] ADDR_CAP_A    = 4'h3;
    localparam logic [3:0] ADDR_CAP_B    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
    localparam logic [3:0] ADDR_IRQ_EN   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLR  = 4'h7;

    // ==========================================================
    // Field values and reset values.
    localparam logic [2:0]  OP_PULSE_WIDTH = 3'h6;
    localparam logic        EDGE_RISING    = 1'h0;
    localparam logic        STYLE_DOUBLE   = 1'h0;
    localparam logic [15:0] COUNT_ZERO     = 16'h0000;
    localparam logic [15:0] COUNT_ONES     = 16'hFFFF;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam logic [3:0]  IRQ_RESET      = 4'h0;
    localparam int          CTRL_RUN_BIT   = 0;
    localparam int          CTRL_OVFEN_BIT = 1;

    // Interrupt cause positions in status, enable and clear registers.
    localparam int IRQ_START = 0;
    localparam int IRQ_CAP_B = 1;
    localparam int IRQ_CAP_A = 2;
    localparam int IRQ_OVF   = 3;

    // ==========================================================
    // Mode register layout, low bit last.
    typedef struct packed {
        logic       capture_style_select;
        logic       trigger_edge_select;
        logic [2:0] source_clock_select;
        logic [2:0] operating_mode_field;
    } mode_type;

    // Capture status flags, cleared by any status read.
    typedef struct packed {
        logic overflow_flag;
        logic capture_b_flag;
        logic capture_a_flag;
    } flags_type;

    // Measurement sequence.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_COUNT,
        ST_AFTER_B
    } state_type;

endpackage

// ==== logic/source_clock_gen.sv ====
/*
 * Source clock tick generator for the capture counter.
 * Assumes a free running system clock; select 0 ticks every cycle,
 * select n ticks once every 2**n cycles.
 */
`timescale 1ns/1ps

module source_clock_gen #(
    parameter int SEL_WIDTH = 3
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Selection and tick.
    input  wire logic [SEL_WIDTH-1:0] select,
    output logic                      tick
);

    localparam int DIV_WIDTH = (1 << SEL_WIDTH) - 1;

    logic [DIV_WIDTH-1:0] div_q;
    logic [DIV_WIDTH:0]   tick_at;

    // =====================================================
    // Free divider; it never stops so the tick phase is not tied to start.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // One tick candidate per division ratio.
    assign tick_at[0] = 1'b1;
    for (genvar i = 1; i <= DIV_WIDTH; i++) begin : g_tap
        assign tick_at[i] = &div_q[i-1:0];
    end

    assign tick = tick_at[select];

endmodule

// ==== logic/pulse_width_capture_timer.sv ====
/*
 * Pulse width capture timer: a 16-bit up counter that measures the
 * time between edges of the timer input pin and captures it.
 * Assumes a register master that never issues read and write together
 * and an asynchronous input pin that is synchronised here.
 */
// Implementation choices: the address map and the address-and-strobe port.
// Notes on behaviour
// - Mode code 110 selects pulse width measurement.
// - Counter steps on selected internal source clock.
// - Edge select 0 rising, 1 falling start.
// - Style bit 0 double-edge, 1 single-edge.
// - Overflow interrupts only when overflow enable set.
// - Starting the timer zeroes both capture registers.
// - Mode and overflow enable locked while running.
// - Start edge interrupts, then counting begins.
// - Opposite edge captures into B, flag, interrupt.
// - Double-edge: next start captures A, clears counter.
// - Single-edge: opposite edge stops and clears counter.
// - Overflow during capture sets overflow flag.
// - Reading status clears all three flags.
// - Clearing run stops and zeroes the counter.
// - Leading opposite edge neither captures nor interrupts.
`timescale 1ns/1ps

module pulse_width_capture_timer #(
    parameter int CNT_WIDTH = 16
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port.
    input  wire logic [3:0]           addr,
    input  wire logic [15:0]          wdata,
    input  wire logic                 wr,
    input  wire logic                 rd,
    output logic      [15:0]          rdata,
    // Pin and interrupt.
    input  wire logic                 timer_input_pin,
    output logic                      timer_irq_request
);

    // =====================================================
    // Declarations.
    pwc_pkg::mode_type      mode_q;
    pwc_pkg::flags_type     flags_q, flags_d;
    pwc_pkg::state_type     state_q, state_d;
    logic                   run_q;
    logic                   ovf_en_q;
    logic [CNT_WIDTH-1:0]   cnt_q, cnt_d;
    logic [CNT_WIDTH-1:0]   cap_a_q, cap_b_q;
    logic [3:0]             irq_stat_q, irq_en_q, irq_set;
    logic [15:0]            rdata_q, rdata_d;
    logic                   irq_q;
    logic                   pin_s1_q, pin_s2_q, pin_prev_q;
    logic                   tick;
    logic                   rise, fall, start_edge, opp_edge;
    logic                   wr_mode, wr_ctrl, rd_status, wr_irq_clr;
    logic                   run_set, run_clr;
    logic                   measuring, is_pw_mode, is_single;
    logic                   evt_start, evt_cap_b, evt_cap_a, evt_ovf;
    logic                   cnt_wrap;

    // =====================================================
    // Address decoding.
    assign wr_mode    = wr && (addr == pwc_pkg::ADDR_MODE);
    assign wr_ctrl    = wr && (addr == pwc_pkg::ADDR_CONTROL);
    assign rd_status  = rd && (addr == pwc_pkg::ADDR_STATUS);
    assign wr_irq_clr = wr && (addr == pwc_pkg::ADDR_IRQ_CLR);
    assign run_set    = wr_ctrl && wdata[pwc_pkg::CTRL_RUN_BIT] && !run_q;
    assign run_clr    = wr_ctrl && !wdata[pwc_pkg::CTRL_RUN_BIT];

    // Source clock ticks for the counter.
    source_clock_gen #(
        .SEL_WIDTH (3)
    ) u_src (
        .clk    (clk),
        .rst    (rst),
        .select (mode_q.source_clock_select),
        .tick   (tick)
    );

    // =====================================================
    // Pin synchroniser; only the second stage feeds edge detection.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q   <= 1'b0;
            pin_s2_q   <= 1'b0;
            pin_prev_q <= 1'b0;
        end else begin
            pin_s1_q   <= timer_input_pin;
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // Edge classification against the selected start edge.
    assign rise       = pin_s2_q && !pin_prev_q;
    assign fall       = !pin_s2_q && pin_prev_q;
    assign start_edge = (mode_q.trigger_edge_select == pwc_pkg::EDGE_RISING) ? rise : fall;
    assign opp_edge   = (mode_q.trigger_edge_select == pwc_pkg::EDGE_RISING) ? fall : rise;

    assign is_pw_mode = (mode_q.operating_mode_field == pwc_pkg::OP_PULSE_WIDTH);
    assign is_single  = (mode_q.capture_style_select != pwc_pkg::STYLE_DOUBLE);
    assign measuring  = (state_q == pwc_pkg::ST_COUNT) || (state_q == pwc_pkg::ST_AFTER_B);
    assign cnt_wrap   = measuring && tick && (cnt_q == pwc_pkg::COUNT_ONES);

    // Events of the measurement; an edge takes priority over a wrap tick.
    assign evt_start = (state_q == pwc_pkg::ST_WAIT_START) && start_edge && run_q;
    assign evt_cap_b = (state_q == pwc_pkg::ST_COUNT) && opp_edge && run_q;
    assign evt_cap_a = (state_q == pwc_pkg::ST_AFTER_B) && start_edge && run_q;
    assign evt_ovf   = cnt_wrap && run_q && !evt_cap_a && !evt_cap_b;

    // =====================================================
    // Sequence and counter next state.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            pwc_pkg::ST_IDLE: begin
                if (run_q && is_pw_mode) begin
                    state_d = pwc_pkg::ST_WAIT_START;
                end
            end
            pwc_pkg::ST_WAIT_START: begin
                // A leading opposite edge is simply ignored here.
                if (start_edge) begin
                    state_d = pwc_pkg::ST_COUNT;
                    cnt_d   = pwc_pkg::COUNT_ZERO;
                end
            end
            pwc_pkg::ST_COUNT: begin
                if (opp_edge && is_single) begin
                    state_d = pwc_pkg::ST_WAIT_START;
                    cnt_d   = pwc_pkg::COUNT_ZERO;
                end else if (opp_edge) begin
                    state_d = pwc_pkg::ST_AFTER_B;
                    cnt_d   = tick ? cnt_q + 1'b1 : cnt_q;
                end else if (tick) begin
                    cnt_d   = cnt_q + 1'b1;
                end
            end
            pwc_pkg::ST_AFTER_B: begin
                if (start_edge) begin
                    state_d = pwc_pkg::ST_COUNT;
                    cnt_d   = pwc_pkg::COUNT_ZERO;
                end else if (tick) begin
                    cnt_d   = cnt_q + 1'b1;
                end
            end
            default: begin
                state_d = pwc_pkg::ST_IDLE;
            end
        endcase
        // Stopping wins over everything and zeroes the counter.
        if (!run_q || run_clr) begin
            state_d = pwc_pkg::ST_IDLE;
            cnt_d   = pwc_pkg::COUNT_ZERO;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= pwc_pkg::ST_IDLE;
            cnt_q   <= pwc_pkg::COUNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // =====================================================
    // Mode and control registers; mode and overflow enable locked while the timer runs, run bit always writable.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q   <= pwc_pkg::MODE_RESET;
            run_q    <= 1'b0;
            ovf_en_q <= 1'b0;
        end else begin
            if (wr_mode && !run_q) begin
                mode_q <= wdata[7:0];
            end
            if (wr_ctrl && !run_q) begin
                ovf_en_q <= wdata[pwc_pkg::CTRL_OVFEN_BIT];
            end
            if (wr_ctrl) begin
                run_q <= wdata[pwc_pkg::CTRL_RUN_BIT];
            end
        end
    end

    // Capture registers; a fresh start zeroes both.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_a_q <= pwc_pkg::COUNT_ZERO;
            cap_b_q <= pwc_pkg::COUNT_ZERO;
        end else if (run_set) begin
            cap_a_q <= pwc_pkg::COUNT_ZERO;
            cap_b_q <= pwc_pkg::COUNT_ZERO;
        end else begin
            if (evt_cap_a) begin
                cap_a_q <= cnt_q;
            end
            if (evt_cap_b) begin
                cap_b_q <= cnt_q;
            end
        end
    end

    // Status flags; a status read clears them but a same-cycle set wins.
    always_comb begin
        flags_d = rd_status ? 3'h0 : flags_q;
        if (evt_cap_a) begin
            flags_d.capture_a_flag = 1'b1;
        end
        if (evt_cap_b) begin
            flags_d.capture_b_flag = 1'b1;
        end
        if (evt_ovf) begin
            flags_d.overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_q <= 3'h0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // =====================================================
    // Interrupt causes; overflow only reaches them when enabled.
    assign irq_set[pwc_pkg::IRQ_START] = evt_start;
    assign irq_set[pwc_pkg::IRQ_CAP_B] = evt_cap_b;
    assign irq_set[pwc_pkg::IRQ_CAP_A] = evt_cap_a;
    assign irq_set[pwc_pkg::IRQ_OVF]   = evt_ovf && ovf_en_q;

    // Sticky causes with write-one-to-clear; a new event beats the clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= pwc_pkg::IRQ_RESET;
            irq_en_q   <= pwc_pkg::IRQ_RESET;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? wdata[3:0] : 4'h0)) | irq_set;
            if (wr && (addr == pwc_pkg::ADDR_IRQ_EN)) begin
                irq_en_q <= wdata[3:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    // =====================================================
    // Read mux; captures come out as one 16-bit word.
    always_comb begin
        rdata_d = 16'h0000;
        if (addr == pwc_pkg::ADDR_MODE) begin
            rdata_d = {8'h00, mode_q};
        end else if (addr == pwc_pkg::ADDR_CONTROL) begin
            rdata_d = {14'h0000, ovf_en_q, run_q};
        end else if (addr == pwc_pkg::ADDR_STATUS) begin
            rdata_d = {11'h000, state_q, flags_q};
        end else if (addr == pwc_pkg::ADDR_CAP_A) begin
            rdata_d = cap_a_q;
        end else if (addr == pwc_pkg::ADDR_CAP_B) begin
            rdata_d = cap_b_q;
        end else if (addr == pwc_pkg::ADDR_IRQ_STAT) begin
            rdata_d = {12'h000, irq_stat_q};
        end else if (addr == pwc_pkg::ADDR_IRQ_EN) begin
            rdata_d = {12'h000, irq_en_q};
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rd ? rdata_d : 16'h0000;
        end
    end

    assign rdata             = rdata_q;
    assign timer_irq_request = irq_q;

    // =====================================================
    // Checks on the measurement sequence.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_run_clears_caps: assert property (run_set |=> cap_a_q == 16'h0000 && cap_b_q == 16'h0000)
        else $error("capture registers not cleared at start");
    a_mode_locked: assert property (run_q && wr_mode |=> $stable(mode_q))
        else $error("mode register changed while running");
    a_ovfen_locked: assert property (run_q && wr_ctrl |=> $stable(ovf_en_q))
        else $error("overflow enable changed while running");
    a_start_irq: assert property (evt_start |=> irq_stat_q[pwc_pkg::IRQ_START] ##1 state_q != pwc_pkg::ST_WAIT_START || !run_q)
        else $error("start edge did not raise cause");
    a_capb_copy: assert property (evt_cap_b && !run_clr |=> cap_b_q == $past(cnt_q) && flags_q.capture_b_flag)
        else $error("capture B wrong");
    a_capa_clear: assert property (evt_cap_a && !run_clr |=> cnt_q == 16'h0000 && flags_q.capture_a_flag)
        else $error("capture A did not clear counter");
    a_single_stop: assert property (evt_cap_b && is_single && !run_clr |=> state_q == pwc_pkg::ST_WAIT_START && cnt_q == 16'h0000)
        else $error("single-edge stop failed");
    a_stop_clear: assert property (run_clr |=> state_q == pwc_pkg::ST_IDLE && cnt_q == 16'h0000)
        else $error("stop did not clear counter");
    // A cause bit left over from an earlier capture must not count as a new one, so look for a rise.
    a_first_opp: assert property (
        state_q == pwc_pkg::ST_WAIT_START && opp_edge
        |=> $stable(cap_b_q) && !$rose(irq_stat_q[pwc_pkg::IRQ_CAP_B])
            && !$rose(flags_q.capture_b_flag))
        else $error("leading opposite edge captured");
    a_status_clear: assert property (rd_status && !evt_cap_a && !evt_cap_b && !evt_ovf |=> flags_q == 3'h0)
        else $error("status read did not clear flags");
    a_ovf_gate: assert property (evt_ovf && !ovf_en_q && !irq_stat_q[pwc_pkg::IRQ_OVF] |=> !irq_stat_q[pwc_pkg::IRQ_OVF])
        else $error("overflow cause without enable");
    a_irq_level: assert property (##1 timer_irq_request == $past(|(irq_stat_q & irq_en_q)))
        else $error("interrupt level mismatch");

    // Counting, capture values and the mode gate.
    a_count_step: assert property (
        state_q == pwc_pkg::ST_COUNT && tick && !opp_edge && !run_clr
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter did not step on a source tick");
    a_count_hold: assert property (
        state_q == pwc_pkg::ST_COUNT && !tick && !opp_edge && !run_clr
        |=> $stable(cnt_q))
        else $error("counter moved without a source tick");
    a_capa_copy: assert property (
        evt_cap_a && !run_clr
        |=> cap_a_q == $past(cnt_q))
        else $error("capture A does not hold the count");
    a_ovf_flag: assert property (
        evt_ovf
        |=> flags_q.overflow_flag)
        else $error("overflow flag not set on a wrap");
    a_ovf_cause: assert property (
        evt_ovf && ovf_en_q
        |=> irq_stat_q[pwc_pkg::IRQ_OVF])
        else $error("enabled overflow did not raise its cause");
    a_mode_gate: assert property (
        state_q == pwc_pkg::ST_IDLE && !is_pw_mode
        |=> state_q == pwc_pkg::ST_IDLE)
        else $error("timer left idle in another mode");

    c_double_cycle: cover property (evt_cap_b ##[1:1000] evt_cap_a);
    c_single_cycle: cover property (evt_cap_b && is_single ##[1:1000] evt_start);
    c_overflow:     cover property (evt_ovf && ovf_en_q);
    c_leading_opp:  cover property (state_q == pwc_pkg::ST_WAIT_START && opp_edge);

endmodule

// ==== verif/pulse_source.sv ====
/*
 * Behavioural model of the external pulse source on the timer input pin.
 * Assumes the bench calls drive() in order and shares the system clock.
 */
`timescale 1ns/1ps

module pulse_source (
    // Clock.
    input  wire logic clk,
    // Driven pin.
    output logic      pin
);
    // ==========================================================
    // Level driver
    // The pin starts low so that the bench decides the first edge.
    initial begin
        pin = 1'b0;
    end

    // Change the level just after an edge and hold it for whole cycles.
    // Short levels would vanish in the synchroniser, so callers hold many cycles.
    task automatic drive(input logic level, input int cycles);
        @(posedge clk);
        pin <= level;
        repeat (cycles) @(posedge clk);
    endtask
endmodule

// ==== verif/testbench.sv ====
/*
 * Self-checking bench of the pulse width capture timer.
 * Assumes the register map of the package and a 100 ns system clock.
 */
`timescale 1ns/1ps

module testbench;
    logic        clk;
    logic        rst;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        pin;
    logic        irq;
    int          n_errors;
    int          n_checks;
    logic [15:0] v;
    logic [15:0] c1;

    // ==========================================================
    // Design and pulse source
    pulse_width_capture_timer #(.CNT_WIDTH(16)) dut (
        .clk               (clk),
        .rst               (rst),
        .addr              (addr),
        .wdata             (wdata),
        .wr                (wr),
        .rd                (rd),
        .rdata             (rdata),
        .timer_input_pin   (pin),
        .timer_irq_request (irq)
    );
    pulse_source src (.clk(clk), .pin(pin));

    // Free running system clock.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // Register port tasks
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample it there.
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd_reg(a, d);
        chk(d, exp);
    endtask

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized for the long overflow run plus margin.
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // ==========================================================
    // Test sequence
    initial begin
        rst      = 1'b1;
        addr     = 4'h0;
        wdata    = 16'h0000;
        wr       = 1'b0;
        rd       = 1'b0;
        n_errors = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Every register, the clear register and one unmapped word read zero.
        for (int a = 0; a < 9; a++) begin
            rchk(a[3:0], 16'h0000);
        end
        $display("Test reset values done.");

        // Single-edge, rising start; pin already high so the first edge is opposite.
        src.drive(1'b1, 10);
        wr_reg(pwc_pkg::ADDR_IRQ_EN, 16'h000F);
        wr_reg(pwc_pkg::ADDR_MODE, 16'h0086);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0001);
        wr_reg(pwc_pkg::ADDR_MODE, 16'h0000);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0003);
        rchk(pwc_pkg::ADDR_MODE, 16'h0086);
        rchk(pwc_pkg::ADDR_CONTROL, 16'h0001);
        src.drive(1'b0, 12);
        rchk(pwc_pkg::ADDR_IRQ_STAT, 16'h0000);
        rchk(pwc_pkg::ADDR_STATUS, 16'h0008);
        src.drive(1'b1, 40);
        src.drive(1'b0, 12);
        rchk(pwc_pkg::ADDR_IRQ_STAT, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        rd_reg(pwc_pkg::ADDR_CAP_B, c1);
        rchk(pwc_pkg::ADDR_STATUS, 16'h000A);
        rchk(pwc_pkg::ADDR_STATUS, 16'h0008);
        wr_reg(pwc_pkg::ADDR_IRQ_CLR, 16'h000F);
        rchk(pwc_pkg::ADDR_IRQ_STAT, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        src.drive(1'b1, 80);
        src.drive(1'b0, 12);
        rd_reg(pwc_pkg::ADDR_CAP_B, v);
        chk(v - c1, 16'h0028);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0000);
        rchk(pwc_pkg::ADDR_STATUS, 16'h0002);
        $display("Test single-edge capture done.");

        // Double-edge, falling start, tick every second cycle.
        src.drive(1'b1, 10);
        wr_reg(pwc_pkg::ADDR_IRQ_CLR, 16'h000F);
        wr_reg(pwc_pkg::ADDR_MODE, 16'h004E);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0001);
        rchk(pwc_pkg::ADDR_CAP_B, 16'h0000);
        src.drive(1'b0, 40);
        src.drive(1'b1, 19);
        src.drive(1'b0, 12);
        rd_reg(pwc_pkg::ADDR_CAP_B, c1);
        rd_reg(pwc_pkg::ADDR_CAP_A, v);
        // The high level lasts 20 cycles, which always hold ten ticks, whatever the phase.
        chk(v - c1, 16'h000A);
        rd_reg(pwc_pkg::ADDR_STATUS, v);
        chk({13'h0000, v[2:0]}, 16'h0003);
        rd_reg(pwc_pkg::ADDR_IRQ_STAT, v);
        chk({14'h0000, v[2:1]}, 16'h0003);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0000);
        $display("Test double-edge capture done.");

        // Overflow with its interrupt enabled; the pulse outlasts a full wrap.
        src.drive(1'b0, 10);
        wr_reg(pwc_pkg::ADDR_IRQ_CLR, 16'h000F);
        rd_reg(pwc_pkg::ADDR_STATUS, v);
        wr_reg(pwc_pkg::ADDR_MODE, 16'h0086);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0003);
        src.drive(1'b1, 65600);
        rchk(pwc_pkg::ADDR_IRQ_STAT, 16'h0009);
        rd_reg(pwc_pkg::ADDR_STATUS, v);
        chk({15'h0000, v[2]}, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(pwc_pkg::ADDR_IRQ_EN, 16'h0000);
        // The interrupt output is registered, so it falls one cycle after the enable.
        @(posedge clk);
        #1;
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(pwc_pkg::ADDR_STATUS, v);
        chk({13'h0000, v[2:0]}, 16'h0000);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0000);
        $display("Test overflow done.");

        // Any other mode code leaves the timer idle, so edges cause nothing.
        wr_reg(pwc_pkg::ADDR_IRQ_CLR, 16'h000F);
        wr_reg(pwc_pkg::ADDR_MODE, 16'h0085);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0001);
        src.drive(1'b0, 12);
        src.drive(1'b1, 12);
        rchk(pwc_pkg::ADDR_STATUS, 16'h0000);
        rchk(pwc_pkg::ADDR_IRQ_STAT, 16'h0000);
        wr_reg(pwc_pkg::ADDR_CONTROL, 16'h0000);
        $display("Test other mode done.");
        print_verdict();
    end
endmodule
